// file: pkg/codec_consts.svh
`ifndef CODEC_CONSTS_SVH
`define CODEC_CONSTS_SVH

// Frame layout: two 16-bit slots after each frame sync
`define SLOT_BITS      16
`define LAST_BIT       6'h1f
`define SLOT_LAST      4'hf
`define SLOT_SEL_BIT   4

// Conversion word fields
`define VALID_BIT      15
`define PAD_ZEROS      7'h00
`define ADC_POS_MAX    15'h3fff
`define ADC_NEG_MAX    15'h4000

// Gain code: 0 is -36 dB, 1.5 dB a step, 32 is +12 dB
`define GAIN_CODE_MAX  6'h20
`define GAIN_RST       6'h18

// Companding constants
`define MU_BIAS        14'h0021
`define MU_CLIP        13'h1fff
`define ALAW_XOR       8'h55

// Crosspoint sink that is the line output
`define LINE_SINK      3

`endif

// file: pkg/codec_pkg.sv
package codec_pkg;

    // Word coding selected per codec
    typedef enum logic [1:0] {
        CODE_LINEAR = 2'h0,
        CODE_ALAW   = 2'h1,
        CODE_MULAW  = 2'h2
    } coding_type;

    // Serial link state, Gray along idle, shift, done
    typedef enum logic [1:0] {
        LINK_IDLE  = 2'h0,
        LINK_SHIFT = 2'h1,
        LINK_DONE  = 2'h3
    } link_state_type;

endpackage

// file: hw/bit_sync.sv
module bit_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] hold_ff;

    // Two stages; only the second stage is visible outside
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_ff <= '0;
            hold_ff <= '0;
        end else begin
            meta_ff <= async_in;
            hold_ff <= meta_ff;
        end
    end

    assign sync_out = hold_ff;

endmodule // bit_sync

// file: hw/compander_encode.sv
`include "codec_consts.svh"

module compander_encode
    import codec_pkg::*;
(
    input  wire logic [15:0] linear,
    input  wire coding_type  law,
    output logic      [7:0]  code
);

    // Index of the highest set bit, zero when none
    function automatic logic [2:0] top_seg(input logic [7:0] b);
        top_seg = 3'h0;
        for (int k = 0; k < 8; k++) begin
            if (b[k]) begin
                top_seg = 3'(k);
            end
        end
    endfunction

    logic        neg;
    logic [14:0] mag;
    logic [13:0] mu_sum;
    logic [12:0] mu_b;
    logic [2:0]  mu_seg;
    logic [3:0]  mu_mant;
    logic [11:0] a_m;
    logic [2:0]  a_seg;
    logic [3:0]  a_mant;

    // Ones-complement magnitude avoids the overflow of negating full scale
    assign neg     = linear[15];
    assign mag     = neg ? ~linear[14:0] : linear[14:0];
    // Mu-law: 13-bit magnitude plus bias, clipped to 13 bits
    assign mu_sum  = {1'b0, mag[14:2]} + `MU_BIAS;
    assign mu_b    = mu_sum[13] ? `MU_CLIP : mu_sum[12:0];
    assign mu_seg  = top_seg(mu_b[12:5]);
    assign mu_mant = 4'(mu_b >> ({1'b0, mu_seg} + 4'h1));
    // A-law: 12-bit magnitude, segment zero is linear
    assign a_m     = mag[14:3];
    assign a_seg   = (|a_m[11:5]) ? top_seg({1'b0, a_m[11:5]}) + 3'h1 : 3'h0;
    assign a_mant  = 4'(a_m >> ((a_seg == 3'h0) ? 3'h1 : a_seg));

    assign code = (law == CODE_ALAW) ? ({~neg, a_seg, a_mant} ^ `ALAW_XOR)
                                     : {~neg, ~mu_seg, ~mu_mant};

endmodule // compander_encode

// file: hw/dual_codec_serial_datapath.sv
`include "codec_consts.svh"

module dual_codec_serial_datapath
    import codec_pkg::*;
#(
    parameter int N_SRC  = 4,
    parameter int N_SINK = 4
) (
    input  wire logic              REF_CLK,
    input  wire logic              RST_B,
    input  wire logic              BCLK,
    input  wire logic              FRAME_SYNC,
    input  wire logic              DIN,
    input  wire logic              HARDWARE_POWER_DOWN,
    output logic                   DOUT,
    output logic                   DOUT_OE,
    input  wire logic [14:0]       ADC_DATA_1,
    input  wire logic [14:0]       ADC_DATA_2,
    input  wire logic              ADC_STROBE_1,
    input  wire logic              ADC_STROBE_2,
    input  wire coding_type        CODING_1,
    input  wire coding_type        CODING_2,
    input  wire logic [5:0]        ADC_GAIN_1,
    input  wire logic [5:0]        ADC_GAIN_2,
    input  wire logic [5:0]        DAC_GAIN_1,
    input  wire logic [5:0]        DAC_GAIN_2,
    input  wire logic              HIGHPASS_BYPASS_1,
    input  wire logic              HIGHPASS_BYPASS_2,
    input  wire logic [N_SRC-1:0]  SRC_CONNECT_1,
    input  wire logic [N_SRC-1:0]  SRC_CONNECT_2,
    input  wire logic [N_SINK-1:0] SINK_CONNECT_1,
    input  wire logic [N_SINK-1:0] SINK_CONNECT_2,
    input  wire logic [N_SINK-1:0] SINK_MUTE_1,
    input  wire logic [N_SINK-1:0] SINK_MUTE_2,
    input  wire logic              SOFT_RESET_1,
    input  wire logic              SOFT_RESET_2,
    input  wire logic              OVF_CLEAR_1,
    input  wire logic              OVF_CLEAR_2,
    output logic      [15:0]       DAC_DATA_1,
    output logic      [15:0]       DAC_DATA_2,
    output logic                   DAC_STROBE_1,
    output logic                   DAC_STROBE_2,
    output logic                   OVERFLOW_1,
    output logic                   OVERFLOW_2,
    output logic      [5:0]        ADC_GAIN_Q_1,
    output logic      [5:0]        ADC_GAIN_Q_2,
    output logic      [5:0]        DAC_GAIN_Q_1,
    output logic      [5:0]        DAC_GAIN_Q_2,
    output logic                   HIGHPASS_BYPASS_Q_1,
    output logic                   HIGHPASS_BYPASS_Q_2,
    output logic      [N_SRC-1:0]  SRC_EN_1,
    output logic      [N_SRC-1:0]  SRC_EN_2,
    output logic      [N_SINK-1:0] SINK_EN_1,
    output logic      [N_SINK-1:0] SINK_EN_2,
    output logic                   LINE_OUT_CONFLICT
);

    // Out-of-range gain codes are clamped to +12 dB
    function automatic logic [5:0] clamp_gain(input logic [5:0] g);
        clamp_gain = (g > `GAIN_CODE_MAX) ? `GAIN_CODE_MAX : g;
    endfunction

    // Pin synchronisers
    logic [3:0]     pins_s;
    logic           bclk_s;
    logic           frame_sync_s;
    logic           din_s;
    logic           pd_s;

    bit_sync #(
        .WIDTH(4)
    ) u_pin_sync (
        .clk      (REF_CLK),
        .rst_b    (RST_B),
        .async_in ({BCLK, FRAME_SYNC, DIN, HARDWARE_POWER_DOWN}),
        .sync_out (pins_s)
    );

    assign bclk_s  = pins_s[3];
    assign frame_sync_s = pins_s[2];
    assign din_s   = pins_s[1];
    assign pd_s    = pins_s[0];

    // Link state and counters
    logic           bclk_d_ff;
    link_state_type state_ff;
    link_state_type nxt_state;
    logic [5:0]     cnt_ff;
    logic [5:0]     nxt_cnt;
    logic [31:0]    tx_ff;
    logic           dout_ff;
    logic           oe_ff;
    logic [14:0]    rx_ff;

    // Bit clock edges found on the synchronised copy
    logic           bclk_rise;
    logic           bclk_fall;
    logic           frame_go;
    logic           bit_go;
    logic           last_bit;
    logic           rx_take;
    logic           word_done;
    logic           slot_sel;
    logic [15:0]    rx_word;

    assign bclk_rise = bclk_s & ~bclk_d_ff;
    assign bclk_fall = ~bclk_s & bclk_d_ff;
    assign frame_go  = bclk_rise & frame_sync_s & ~pd_s;
    assign bit_go    = bclk_rise & ~frame_sync_s & ~pd_s & (state_ff == LINK_SHIFT);
    assign last_bit  = (cnt_ff == `LAST_BIT);
    assign rx_take   = bclk_fall & ~pd_s & (state_ff == LINK_SHIFT);
    assign word_done = rx_take & (cnt_ff[3:0] == `SLOT_LAST);
    assign slot_sel  = cnt_ff[`SLOT_SEL_BIT];
    assign rx_word   = {rx_ff, din_s};

    // Next state; power-down resets the link state, the count and the DOUT bit, not the settings
    assign nxt_state = pd_s                ? LINK_IDLE  :
                       frame_go            ? LINK_SHIFT :
                       (bit_go & last_bit) ? LINK_DONE  : state_ff;
    assign nxt_cnt   = (pd_s | frame_go) ? 6'h00 :
                       bit_go            ? cnt_ff + 6'h01 : cnt_ff;

    // Per-codec arrays
    logic [14:0]       adc_in [2];
    logic              adc_stb [2];
    coding_type        code_in [2];
    logic [5:0]        adc_g_in [2];
    logic [5:0]        dac_g_in [2];
    logic              hp_in [2];
    logic [N_SRC-1:0]  src_in [2];
    logic [N_SINK-1:0] sink_in [2];
    logic [N_SINK-1:0] mute_in [2];
    logic              srst [2];
    logic              ovf_clr [2];
    logic [15:0]       tx_word [2];
    logic [15:0]       dac_ff [2];
    logic              dac_stb_ff [2];
    logic              ovf_ff [2];
    logic [5:0]        adc_g_ff [2];
    logic [5:0]        dac_g_ff [2];
    logic              hp_ff [2];
    logic [N_SRC-1:0]  src_ff [2];
    logic [N_SINK-1:0] sink_ff [2];
    logic              conflict_ff;

    assign adc_in[0]   = ADC_DATA_1;
    assign adc_in[1]   = ADC_DATA_2;
    assign adc_stb[0]  = ADC_STROBE_1;
    assign adc_stb[1]  = ADC_STROBE_2;
    assign code_in[0]  = CODING_1;
    assign code_in[1]  = CODING_2;
    assign adc_g_in[0] = ADC_GAIN_1;
    assign adc_g_in[1] = ADC_GAIN_2;
    assign dac_g_in[0] = DAC_GAIN_1;
    assign dac_g_in[1] = DAC_GAIN_2;
    assign hp_in[0]    = HIGHPASS_BYPASS_1;
    assign hp_in[1]    = HIGHPASS_BYPASS_2;
    assign src_in[0]   = SRC_CONNECT_1;
    assign src_in[1]   = SRC_CONNECT_2;
    assign sink_in[0]  = SINK_CONNECT_1;
    assign sink_in[1]  = SINK_CONNECT_2;
    assign mute_in[0]  = SINK_MUTE_1;
    assign mute_in[1]  = SINK_MUTE_2;
    assign srst[0]     = SOFT_RESET_1;
    assign srst[1]     = SOFT_RESET_2;
    assign ovf_clr[0]  = OVF_CLEAR_1;
    assign ovf_clr[1]  = OVF_CLEAR_2;

    for (genvar i = 0; i < 2; i++) begin : g_codec
        logic [14:0]       sample_ff;
        logic              fresh_ff;
        logic              armed_ff;
        coding_type        mode_ff;
        logic [7:0]        comp;
        logic              full_scale;
        logic              my_slot;
        logic [N_SINK-1:0] sink_req;

        compander_encode u_comp (
            .linear ({sample_ff, 1'b0}),
            .law    (mode_ff),
            .code   (comp)
        );

        assign full_scale = (adc_in[i] == `ADC_POS_MAX) | (adc_in[i] == `ADC_NEG_MAX);
        assign my_slot    = (slot_sel == 1'(i));
        assign sink_req   = sink_in[i] & ~mute_in[i];

        // Slot word: valid flag on top; the arming frame is served too, else a sample is lost
        assign tx_word[i] = (srst[i] | ~(armed_ff | frame_go)) ? 16'h0000 :
                            (mode_ff == CODE_LINEAR)            ? {fresh_ff, sample_ff}
                                                                : {fresh_ff, `PAD_ZEROS, comp};

        // Latest ADC sample; a strobe in the load cycle keeps the flag for next frame
        always_ff @(posedge REF_CLK or negedge RST_B) begin
            if (!RST_B) begin
                sample_ff <= 15'h0000;
                fresh_ff  <= 1'b0;
            end else if (srst[i]) begin
                sample_ff <= 15'h0000;
                fresh_ff  <= 1'b0;
            end else if (adc_stb[i]) begin
                sample_ff <= adc_in[i];
                fresh_ff  <= 1'b1;
            end else if (frame_go) begin
                fresh_ff  <= 1'b0;
            end
        end

        // Sticky overflow; a hit in the clear cycle wins
        always_ff @(posedge REF_CLK or negedge RST_B) begin
            if (!RST_B) begin
                ovf_ff[i] <= 1'b0;
            end else if (srst[i]) begin
                ovf_ff[i] <= 1'b0;
            end else if (adc_stb[i] & full_scale) begin
                ovf_ff[i] <= 1'b1;
            end else if (ovf_clr[i]) begin
                ovf_ff[i] <= 1'b0;
            end
        end

        // Arms at the first frame start after soft reset is released
        always_ff @(posedge REF_CLK or negedge RST_B) begin
            if (!RST_B) begin
                armed_ff <= 1'b0;
            end else if (srst[i]) begin
                armed_ff <= 1'b0;
            end else if (frame_go) begin
                armed_ff <= 1'b1;
            end
        end

        // Control settings, returned to defaults while soft reset holds
        always_ff @(posedge REF_CLK or negedge RST_B) begin
            if (!RST_B) begin
                mode_ff     <= CODE_LINEAR;
                adc_g_ff[i] <= `GAIN_RST;
                dac_g_ff[i] <= `GAIN_RST;
                hp_ff[i]    <= 1'b0;
                src_ff[i]   <= '0;
                sink_ff[i]  <= '0;
            end else if (srst[i]) begin
                mode_ff     <= CODE_LINEAR;
                adc_g_ff[i] <= `GAIN_RST;
                dac_g_ff[i] <= `GAIN_RST;
                hp_ff[i]    <= 1'b0;
                src_ff[i]   <= '0;
                sink_ff[i]  <= '0;
            end else begin
                mode_ff     <= code_in[i];
                adc_g_ff[i] <= clamp_gain(adc_g_in[i]);
                dac_g_ff[i] <= clamp_gain(dac_g_in[i]);
                hp_ff[i]    <= hp_in[i];
                src_ff[i]   <= src_in[i];
                sink_ff[i]  <= sink_req;
            end
        end

        // DAC word handed over when its slot's last bit is sampled
        always_ff @(posedge REF_CLK or negedge RST_B) begin
            if (!RST_B) begin
                dac_ff[i]     <= 16'h0000;
                dac_stb_ff[i] <= 1'b0;
            end else begin
                dac_stb_ff[i] <= word_done & my_slot & armed_ff & ~srst[i];
                if (word_done & my_slot & armed_ff & ~srst[i]) begin
                    dac_ff[i] <= rx_word;
                end
            end
        end
    end

    // Link state, count and edge history
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            bclk_d_ff <= 1'b0;
            state_ff  <= LINK_IDLE;
            cnt_ff    <= 6'h00;
        end else begin
            bclk_d_ff <= bclk_s;
            state_ff  <= nxt_state;
            cnt_ff    <= nxt_cnt;
        end
    end

    // Transmit shifter: both slots loaded at frame start, codec one first
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            tx_ff   <= 32'h0000_0000;
            dout_ff <= 1'b0;
            oe_ff   <= 1'b0;
        end else begin
            oe_ff <= (nxt_state == LINK_SHIFT);
            if (frame_go) begin
                tx_ff   <= {tx_word[0], tx_word[1]};
                dout_ff <= tx_word[0][`VALID_BIT];
            end else if (pd_s | (bit_go & last_bit)) begin
                dout_ff <= 1'b0; // A frame cut by power-down must not leave a stale bit
            end else if (bit_go) begin
                tx_ff   <= {tx_ff[30:0], 1'b0};
                dout_ff <= tx_ff[30];
            end
        end
    end

    // Receive shifter, one bit per falling edge
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rx_ff <= 15'h0000;
        end else if (rx_take) begin
            rx_ff <= rx_word[14:0];
        end
    end

    // Both codecs on the line output is flagged, not silently merged
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            conflict_ff <= 1'b0;
        end else begin
            conflict_ff <= sink_ff[0][`LINE_SINK] & sink_ff[1][`LINE_SINK];
        end
    end

    // Ports straight from flip-flops
    assign DOUT                = dout_ff;
    assign DOUT_OE             = oe_ff;
    assign DAC_DATA_1          = dac_ff[0];
    assign DAC_DATA_2          = dac_ff[1];
    assign DAC_STROBE_1        = dac_stb_ff[0];
    assign DAC_STROBE_2        = dac_stb_ff[1];
    assign OVERFLOW_1          = ovf_ff[0];
    assign OVERFLOW_2          = ovf_ff[1];
    assign ADC_GAIN_Q_1        = adc_g_ff[0];
    assign ADC_GAIN_Q_2        = adc_g_ff[1];
    assign DAC_GAIN_Q_1        = dac_g_ff[0];
    assign DAC_GAIN_Q_2        = dac_g_ff[1];
    assign HIGHPASS_BYPASS_Q_1 = hp_ff[0];
    assign HIGHPASS_BYPASS_Q_2 = hp_ff[1];
    assign SRC_EN_1            = src_ff[0];
    assign SRC_EN_2            = src_ff[1];
    assign SINK_EN_1           = sink_ff[0];
    assign SINK_EN_2           = sink_ff[1];
    assign LINE_OUT_CONFLICT   = conflict_ff;

endmodule // dual_codec_serial_datapath

// file: tb/codec_link_assertions.sv
module codec_link_checker #(
    parameter int N_SRC  = 4,
    parameter int N_SINK = 4
) (
    input wire logic              REF_CLK,
    input wire logic              RST_B,
    input wire logic              BCLK,
    input wire logic              DOUT,
    input wire logic              DOUT_OE,
    input wire logic [14:0]       ADC_DATA_1,
    input wire logic              ADC_STROBE_1,
    input wire logic              SOFT_RESET_1,
    input wire logic              SOFT_RESET_2,
    input wire logic              OVF_CLEAR_1,
    input wire logic [5:0]        ADC_GAIN_1,
    input wire logic [5:0]        DAC_GAIN_2,
    input wire logic [N_SINK-1:0] SINK_CONNECT_2,
    input wire logic [N_SINK-1:0] SINK_MUTE_2,
    input wire logic              DAC_STROBE_1,
    input wire logic              DAC_STROBE_2,
    input wire logic              OVERFLOW_1,
    input wire logic [5:0]        ADC_GAIN_Q_1,
    input wire logic [5:0]        DAC_GAIN_Q_2,
    input wire logic [N_SINK-1:0] SINK_EN_2
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    // Age of the last bit clock rise, saturating so a launch on the fall is caught
    logic       bclk_d_ff;
    logic [2:0] rise_age_ff;
    logic [2:0] nxt_rise_age;
    logic [8:0] oe_cnt_ff;
    assign nxt_rise_age = (BCLK && !bclk_d_ff) ? 3'h0 : ((rise_age_ff == 3'h7) ? 3'h7 : rise_age_ff + 3'h1);

    // Helper registers: bit clock history and length of the drive window
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            bclk_d_ff   <= 1'b0;
            rise_age_ff <= 3'h7;
            oe_cnt_ff   <= 9'h000;
        end else begin
            bclk_d_ff   <= BCLK;
            rise_age_ff <= nxt_rise_age;
            oe_cnt_ff   <= DOUT_OE ? oe_cnt_ff + 9'h001 : 9'h000;
        end
    end

    // Second word of a frame follows the first by sixteen bit periods
    sequence s_second_word;
        ##[126:130] DAC_STROBE_2;
    endsequence

    property p_ovf_set;
        ADC_STROBE_1 && !SOFT_RESET_1 && (ADC_DATA_1 == 15'h3fff || ADC_DATA_1 == 15'h4000) |=> OVERFLOW_1;
    endproperty
    property p_ovf_hold;
        OVERFLOW_1 && !OVF_CLEAR_1 && !SOFT_RESET_1 |=> OVERFLOW_1;
    endproperty
    property p_adc_gain;
        !SOFT_RESET_1 ##1 !SOFT_RESET_1 |-> ADC_GAIN_Q_1 == (($past(ADC_GAIN_1) > 6'h20) ? 6'h20 : $past(ADC_GAIN_1));
    endproperty
    property p_dac_gain;
        !SOFT_RESET_2 ##1 !SOFT_RESET_2 |-> DAC_GAIN_Q_2 == (($past(DAC_GAIN_2) > 6'h20) ? 6'h20 : $past(DAC_GAIN_2));
    endproperty
    property p_sink_en;
        !SOFT_RESET_2 ##1 !SOFT_RESET_2 |-> SINK_EN_2 == $past(SINK_CONNECT_2 & ~SINK_MUTE_2);
    endproperty
    property p_launch;
        $changed(DOUT) |-> rise_age_ff inside {[3'h1:3'h5]};
    endproperty
    property p_oe_len;
        $fell(DOUT_OE) |-> oe_cnt_ff inside {[9'd255:9'd257]};
    endproperty
    property p_idle_low;
        !DOUT_OE |-> !DOUT;
    endproperty
    property p_word_pair;
        DAC_STROBE_1 && !SOFT_RESET_2 |-> s_second_word;
    endproperty
    property p_strobe_pulse;
        DAC_STROBE_2 |=> !DAC_STROBE_2 [*8];
    endproperty

    a_ovf_set: assert property (p_ovf_set) else $error("overflow not set by full scale");
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow lost without clear");
    a_adc_gain: assert property (p_adc_gain) else $error("adc gain copy wrong");
    a_dac_gain: assert property (p_dac_gain) else $error("dac gain copy wrong");
    a_sink_en: assert property (p_sink_en) else $error("sink enable wrong");
    a_launch: assert property (p_launch) else $error("dout changed away from bclk rise");
    a_oe_len: assert property (p_oe_len) else $error("drive window not 32 bits");
    a_idle_low: assert property (p_idle_low) else $error("dout active while released");
    a_word_pair: assert property (p_word_pair) else $error("second slot word missing");
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("dac strobe repeated");
endmodule // codec_link_checker

bind dual_codec_serial_datapath codec_link_checker #(.N_SRC(N_SRC), .N_SINK(N_SINK)) link_chk (.*);

// file: tb/host_serial_model.sv
module host_serial_model (
    output logic      bclk,
    output logic      frame_sync,
    output logic      din,
    input  wire logic dout
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bit clock stands low between frames
    initial begin
        bclk = 1'b0;
        frame_sync = 1'b0;
        din = 1'b0;
    end

    // One frame of 33 rises; DOUT is read just before the next rise, where it has settled
    task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
        #3;
        for (int i = 0; i <= 32; i++) begin
            bclk = 1'b1;
            frame_sync = (i == 0);
            din = (i < 32) ? tx[31-i] : ~din;
            #40;
            bclk = 1'b0;
            #40;
            if (i < 32) begin
                rx[31-i] = dout;
            end
        end
    endtask
endmodule // host_serial_model

// file: tb/dual_codec_serial_datapath_bench.sv
module dual_codec_serial_datapath_bench import codec_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic        REF_CLK, RST_B, HARDWARE_POWER_DOWN, DOUT, DOUT_OE, LINE_OUT_CONFLICT;
    wire logic   BCLK, FRAME_SYNC, DIN;
    logic [14:0] ADC_DATA_1, ADC_DATA_2;
    logic        ADC_STROBE_1, ADC_STROBE_2, HIGHPASS_BYPASS_1, HIGHPASS_BYPASS_2, SOFT_RESET_1, SOFT_RESET_2;
    logic        OVF_CLEAR_1, OVF_CLEAR_2, DAC_STROBE_1, DAC_STROBE_2, OVERFLOW_1, OVERFLOW_2;
    logic        HIGHPASS_BYPASS_Q_1, HIGHPASS_BYPASS_Q_2;
    coding_type  CODING_1, CODING_2;
    logic [5:0]  ADC_GAIN_1, ADC_GAIN_2, DAC_GAIN_1, DAC_GAIN_2;
    logic [5:0]  ADC_GAIN_Q_1, ADC_GAIN_Q_2, DAC_GAIN_Q_1, DAC_GAIN_Q_2;
    logic [3:0]  SRC_CONNECT_1, SRC_CONNECT_2, SINK_CONNECT_1, SINK_CONNECT_2, SINK_MUTE_1, SINK_MUTE_2;
    logic [3:0]  SRC_EN_1, SRC_EN_2, SINK_EN_1, SINK_EN_2;
    logic [15:0] DAC_DATA_1, DAC_DATA_2;
    logic [31:0] rx;
    int          failures, n_tests, cycles;

    dual_codec_serial_datapath #(.N_SRC(4), .N_SINK(4)) uut (.*);
    host_serial_model host (.bclk(BCLK), .frame_sync(FRAME_SYNC), .din(DIN), .dout(DOUT));

    // Free-running system clock
    always #5 REF_CLK = ~REF_CLK;

    // Hang guard: the whole run needs well under half this many cycles
    always @(posedge REF_CLK) begin
        cycles++;
        if (cycles == 8000) begin
            failures++;
            stop_test();
        end
    end

    // Inputs set after tick move 1 ns after the edge, the host pins 4 ns after; both away from the sampling instant
    task automatic tick(input int n);
        repeat (n) @(posedge REF_CLK);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic strobe_adc(input logic [14:0] a, input logic [14:0] b);
        {ADC_DATA_1, ADC_DATA_2} = {a, b};
        {ADC_STROBE_1, ADC_STROBE_2} = 2'h3;
        tick(1);
        {ADC_STROBE_1, ADC_STROBE_2} = 2'h0;
        tick(2);
    endtask

    // One frame, then the drive must be released again
    task automatic xfer(input logic [31:0] tx);
        host.frame(tx, rx);
        tick(2);
        chk(DOUT_OE, 32'h0);
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        {REF_CLK, RST_B, HARDWARE_POWER_DOWN, ADC_STROBE_1, ADC_STROBE_2, SOFT_RESET_1, SOFT_RESET_2} = 7'h00;
        {HIGHPASS_BYPASS_1, HIGHPASS_BYPASS_2, OVF_CLEAR_1, OVF_CLEAR_2} = 4'h0;
        {ADC_DATA_1, ADC_DATA_2} = 30'h0;
        {CODING_1, CODING_2} = {CODE_LINEAR, CODE_LINEAR};
        {ADC_GAIN_1, ADC_GAIN_2, DAC_GAIN_1, DAC_GAIN_2} = {4{6'h18}};
        {SRC_CONNECT_1, SRC_CONNECT_2, SINK_CONNECT_1, SINK_CONNECT_2, SINK_MUTE_1, SINK_MUTE_2} = 24'h0;
        failures = 0;
        n_tests = 0;
        cycles = 0;
        tick(4);
        RST_B = 1'b1;
        tick(1000);
        // Linear words both ways, slot order and bit order
        strobe_adc(15'h1234, 15'h7abc);
        xfer(32'hc35a_0ff1);
        chk(rx, 32'h9234_fabc);
        chk({DAC_DATA_1, DAC_DATA_2}, 32'hc35a_0ff1);
        xfer(32'h8001_7ffe);
        chk({rx[31], rx[15]}, 32'h0);
        chk({DAC_DATA_1, DAC_DATA_2}, 32'h8001_7ffe);
        $display("test linear done");
        // Companded words are padded with zeros under the valid flag
        for (int m = 1; m <= 2; m++) begin
            {CODING_1, CODING_2} = {coding_type'(m), coding_type'(m)};
            strobe_adc(15'h0100, 15'h7f00);
            xfer(32'h0);
            chk(rx, (m == 1) ? 32'h80f5_804a : 32'h80db_805b);
        end
        {CODING_1, CODING_2} = {CODE_LINEAR, CODE_LINEAR};
        $display("test companded done");
        // Both full-scale codes flag overflow, one code short does not
        strobe_adc(15'h3fff, 15'h4000);
        chk({OVERFLOW_1, OVERFLOW_2}, 32'h3);
        {OVF_CLEAR_1, OVF_CLEAR_2} = 2'h3;
        tick(1);
        {OVF_CLEAR_1, OVF_CLEAR_2} = 2'h0;
        strobe_adc(15'h3ffe, 15'h4001);
        chk({OVERFLOW_1, OVERFLOW_2}, 32'h0);
        // Full scale and clear in one cycle: the set wins
        {ADC_DATA_1, ADC_STROBE_1, OVF_CLEAR_1, OVF_CLEAR_2} = {15'h3fff, 3'h7};
        tick(1);
        {ADC_STROBE_1, OVF_CLEAR_1, OVF_CLEAR_2} = 3'h0;
        chk({OVERFLOW_1, OVERFLOW_2}, 32'h2);
        $display("test overflow done");
        // Gain clamps, bypass and crosspoint; only one codec on the line output
        {ADC_GAIN_1, ADC_GAIN_2, DAC_GAIN_1, DAC_GAIN_2} = {6'h3f, 6'h00, 6'h20, 6'h21};
        {HIGHPASS_BYPASS_1, HIGHPASS_BYPASS_2} = 2'h2;
        {SRC_CONNECT_1, SRC_CONNECT_2, SINK_CONNECT_1, SINK_CONNECT_2} = {4'h5, 4'ha, 4'h3, 4'hf};
        {SINK_MUTE_1, SINK_MUTE_2} = {4'h1, 4'h6};
        tick(3);
        chk({ADC_GAIN_Q_1, ADC_GAIN_Q_2}, 32'h800);
        chk({DAC_GAIN_Q_1, DAC_GAIN_Q_2}, 32'h820);
        chk({HIGHPASS_BYPASS_Q_1, HIGHPASS_BYPASS_Q_2}, 32'h2);
        chk({SRC_EN_1, SRC_EN_2, SINK_EN_1, SINK_EN_2}, 32'h5a29);
        chk(LINE_OUT_CONFLICT, 32'h0);
        $display("test settings done");
        // Codec one held in soft reset across a power-down; codec two keeps working
        SOFT_RESET_1 = 1'b1;
        HARDWARE_POWER_DOWN = 1'b1;
        tick(20);
        HARDWARE_POWER_DOWN = 1'b0;
        tick(2);
        chk({ADC_GAIN_Q_1, ADC_GAIN_Q_2}, 32'h600);
        repeat (2) xfer(32'h0);
        strobe_adc(15'h0555, 15'h0aaa);
        xfer(32'h1111_2222);
        chk(rx, 32'h0000_8aaa);
        chk({DAC_DATA_1, DAC_DATA_2}, 32'h0000_2222);
        SOFT_RESET_1 = 1'b0;
        tick(2);
        xfer(32'h3333_4444);
        chk({DAC_DATA_1, DAC_DATA_2}, 32'h3333_4444);
        $display("test soft reset done");
        stop_test();
    end
endmodule // dual_codec_serial_datapath_bench
